// *** hdl/fcs_pkg.sv ***
package fcs_pkg;

    // ****************************************
    // Geometry
    // ****************************************
    localparam int unsigned PAGES       = 64;
    localparam int unsigned WORDS       = 8;
    localparam int unsigned PAGE_BITS   = 6;
    localparam int unsigned WORD_BITS   = 3;
    localparam int unsigned MEM_BITS    = 9;
    localparam int unsigned REGION_BITS = 4;
    localparam int unsigned ADDR_W      = 8;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_CMD    = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_FUSE   = 8'h0c;

    // ****************************************
    // Fields
    // ****************************************
    localparam int unsigned BIT_READY  = 0;
    localparam int unsigned BIT_LOCK_ERROR_FLAG  = 2;
    localparam int unsigned BIT_PROGRAMMING_ERROR_FLAG  = 3;
    localparam int unsigned BIT_SECURE = 4;
    localparam int unsigned BIT_QUICK_READ_RESULT_BIT   = 5;
    localparam int unsigned KEY_LSB    = 24;
    localparam int unsigned PAGE_NUMBER_FIELD_LSB  = 8;
    localparam int unsigned CMD_LSB    = 0;
    localparam int unsigned BOOT_LSB   = 17;
    localparam logic [7:0]  CMD_KEY    = 8'ha5;

    // ****************************************
    // Commands
    // ****************************************
    localparam logic [5:0] C_WP   = 6'h01;
    localparam logic [5:0] C_EP   = 6'h02;
    localparam logic [5:0] C_CPB  = 6'h03;
    localparam logic [5:0] C_LP   = 6'h04;
    localparam logic [5:0] C_UP   = 6'h05;
    localparam logic [5:0] C_EA   = 6'h06;
    localparam logic [5:0] C_WGPB = 6'h07;
    localparam logic [5:0] C_EGPB = 6'h08;
    localparam logic [5:0] C_SSB  = 6'h09;
    localparam logic [5:0] C_QPR  = 6'h0c;

    // ****************************************
    // Reset values and answers
    // ****************************************
    localparam logic [31:0] FUSE_RESET = 32'hffffffff;
    localparam logic [2:0]  BOOT_NONE  = 3'h7;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLV   = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_PEND = 3'h1,
        ST_WIPE = 3'h3,
        ST_RUN  = 3'h2,
        ST_DONE = 3'h6
    } fcs_state_e;

endpackage : fcs_pkg

// *** hdl/fcs_sticky_flag.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcs_sticky_flag (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic set,
    input  wire logic clr,
    output var  logic flag
);
    // Set wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag <= 1'b0;
        end else if (set) begin
            flag <= 1'b1;
        end else if (clr) begin
            flag <= 1'b0;
        end
    end
endmodule : fcs_sticky_flag
`default_nettype wire

// *** hdl/fcs_sequencer.sv ***
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module fcs_sequencer (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic                          awvalid,
    output var  logic                          awready,
    input  wire logic [fcs_pkg::ADDR_W-1:0]    awaddr,
    input  wire logic                          wvalid,
    output var  logic                          wready,
    input  wire logic [31:0]                   wdata,
    input  wire logic [3:0]                    wstrb,
    output var  logic                          bvalid,
    input  wire logic                          bready,
    output var  logic [1:0]                    bresp,
    input  wire logic                          arvalid,
    output var  logic                          arready,
    input  wire logic [fcs_pkg::ADDR_W-1:0]    araddr,
    output var  logic                          rvalid,
    input  wire logic                          rready,
    output var  logic [31:0]                   rdata,
    output var  logic [1:0]                    rresp,
    input  wire logic                          hs_req,
    input  wire logic                          hs_write,
    input  wire logic [fcs_pkg::MEM_BITS-1:0]  hs_addr,
    input  wire logic [31:0]                   hs_wdata,
    output var  logic                          hs_ack,
    output var  logic [31:0]                   hs_rdata,
    output var  logic                          volatile_wipe,
    output var  logic                          irq
);

    // ****************************************
    // Declarations
    // ****************************************
    fcs_pkg::fcs_state_e state;
    logic [31:0]    mem [fcs_pkg::PAGES*fcs_pkg::WORDS];
    logic [31:0]    pbuf [fcs_pkg::WORDS];
    logic           aw_have;
    logic           w_have;
    logic [7:0]     aw_addr;
    logic [31:0]    w_data;
    logic           wr_en;
    logic           wr_cmd;
    logic           rd_stat;
    logic           rdy_ie;
    logic           lock_error_flag_ie;
    logic [5:0]     op;
    logic [15:0]    page_number_field;
    logic           ready;
    logic [31:0]    fuse;
    logic           secure;
    logic           quick_read_result_bit;
    logic           qacc;
    logic [8:0]     widx;
    logic           programming_error_flag;
    logic           lock_error_flag;
    logic           programming_error_flag_set;
    logic           lock_error_flag_set;
    logic           cmd_good;
    logic           go;
    logic [5:0]     page;
    logic [2:0]     boot;
    logic [8:0]     boot_lim;
    logic           boot_hit;
    logic           lock_hit;
    logic           last_step;
    logic [8:0]     run_addr;
    logic [31:0]    run_word;

    // ****************************************
    // Decode
    // ****************************************
    assign wr_en    = aw_have && w_have && !bvalid;
    assign wr_cmd   = wr_en && (aw_addr == fcs_pkg::OFS_CMD) && (wstrb == 4'hf);
    assign rd_stat  = arvalid && arready && (araddr == fcs_pkg::OFS_STATUS);
    assign cmd_good = (w_data[31:24] == fcs_pkg::CMD_KEY) &&
                      ((w_data[5:0] >= fcs_pkg::C_WP && w_data[5:0] <= fcs_pkg::C_SSB) ||
                       w_data[5:0] == fcs_pkg::C_QPR);
    assign go       = (state == fcs_pkg::ST_PEND) && !hs_req;
    assign page     = page_number_field[fcs_pkg::PAGE_BITS-1:0];
    assign boot     = fuse[fcs_pkg::BOOT_LSB +: 3];
    assign boot_lim = 9'(9'h002 << (3'h6 - boot));
    assign boot_hit = (boot != fcs_pkg::BOOT_NONE) && ({3'h0, page} < boot_lim);
    always_comb begin
        lock_hit = 1'b0;
        if (op == fcs_pkg::C_EA) begin
            lock_hit = (fuse[15:0] != 16'hffff) || (boot != fcs_pkg::BOOT_NONE);
        end else if (op == fcs_pkg::C_WP || op == fcs_pkg::C_EP) begin
            lock_hit = !fuse[page[5:2]] || boot_hit;
        end
    end
    assign last_step = (op == fcs_pkg::C_EA) ? (widx == 9'h1ff) : (widx[2:0] == 3'h7);
    assign run_addr  = (op == fcs_pkg::C_EA) ? widx : {page, widx[2:0]};
    assign run_word  = mem[run_addr];
    assign programming_error_flag_set = wr_cmd && ((state != fcs_pkg::ST_IDLE) || !cmd_good);
    assign lock_error_flag_set = go && lock_hit;

    // ****************************************
    // Error flags
    // ****************************************
    fcs_sticky_flag u_programming_error_flag (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set     (programming_error_flag_set),
        .clr     (rd_stat),
        .flag    (programming_error_flag)
    );
    fcs_sticky_flag u_lock_error_flag (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set     (lock_error_flag_set),
        .clr     (rd_stat),
        .flag    (lock_error_flag)
    );

    // ****************************************
    // Register bus: write side
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready  <= 1'b0;
            aw_have <= 1'b0;
            w_have  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h00000000;
            bvalid  <= 1'b0;
            bresp   <= fcs_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_have <= 1'b1;
                aw_addr <= awaddr;
                awready <= 1'b0;
            end else if (!aw_have) begin
                awready <= 1'b1;
            end
            if (wvalid && wready) begin
                w_have <= 1'b1;
                w_data <= wdata;
                wready <= 1'b0;
            end else if (!w_have) begin
                wready <= 1'b1;
            end
            if (wr_en) begin
                aw_have <= 1'b0;
                w_have  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= (aw_addr == fcs_pkg::OFS_CTRL || aw_addr == fcs_pkg::OFS_CMD)
                           ? fcs_pkg::RESP_OKAY : fcs_pkg::RESP_SLV;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdy_ie   <= 1'b0;
            lock_error_flag_ie <= 1'b0;
        end else if (wr_en && aw_addr == fcs_pkg::OFS_CTRL) begin
            rdy_ie   <= w_data[fcs_pkg::BIT_READY];
            lock_error_flag_ie <= w_data[fcs_pkg::BIT_LOCK_ERROR_FLAG];
        end
    end

    // ****************************************
    // Register bus: read side
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= fcs_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= fcs_pkg::RESP_OKAY;
            case (araddr)
                fcs_pkg::OFS_CTRL: begin
                    rdata <= 32'({lock_error_flag_ie, 1'b0, rdy_ie});
                end
                fcs_pkg::OFS_CMD: begin
                    rdata <= {8'h00, page_number_field, 2'h0, op};
                end
                fcs_pkg::OFS_STATUS: begin
                    rdata <= 32'({quick_read_result_bit, secure, programming_error_flag, lock_error_flag, 1'b0, ready});
                end
                fcs_pkg::OFS_FUSE: begin
                    rdata <= fuse;
                end
                default: begin
                    rdata <= 32'h00000000;
                    rresp <= fcs_pkg::RESP_SLV;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end

    // ****************************************
    // Command sequencer
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= fcs_pkg::ST_IDLE;
            op    <= 6'h00;
            ready <= 1'b1;
            widx  <= 9'h000;
        end else begin
            case (state)
                fcs_pkg::ST_IDLE: begin
                    if (wr_cmd) begin
                        ready <= 1'b0;
                        op    <= w_data[5:0];
                        state <= cmd_good ? fcs_pkg::ST_PEND : fcs_pkg::ST_DONE;
                    end
                end
                fcs_pkg::ST_PEND: begin
                    widx <= 9'h000;
                    if (go) begin
                        if (lock_hit) begin
                            state <= fcs_pkg::ST_DONE;
                        end else if (op == fcs_pkg::C_EA) begin
                            state <= fcs_pkg::ST_WIPE;
                        end else if (op == fcs_pkg::C_WP || op == fcs_pkg::C_EP ||
                                     op == fcs_pkg::C_QPR) begin
                            state <= fcs_pkg::ST_RUN;
                        end else begin
                            state <= fcs_pkg::ST_DONE;
                        end
                    end
                end
                fcs_pkg::ST_WIPE: begin
                    state <= fcs_pkg::ST_RUN;
                end
                fcs_pkg::ST_RUN: begin
                    widx <= 9'(widx + 9'h001);
                    if (last_step) begin
                        state <= fcs_pkg::ST_DONE;
                    end
                end
                fcs_pkg::ST_DONE: begin
                    ready <= 1'b1;
                    state <= fcs_pkg::ST_IDLE;
                end
                default: begin
                    state <= fcs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Page number field
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            page_number_field <= 16'h0000;
        end else if (wr_cmd && state == fcs_pkg::ST_IDLE) begin
            page_number_field <= w_data[fcs_pkg::PAGE_NUMBER_FIELD_LSB +: 16];
        end else if (hs_req && hs_write && !hs_ack && state == fcs_pkg::ST_IDLE && !wr_cmd) begin
            page_number_field <= 16'(hs_addr[fcs_pkg::MEM_BITS-1:fcs_pkg::WORD_BITS]);
        end
    end

    // ****************************************
    // Fuses and security
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fuse   <= fcs_pkg::FUSE_RESET;
            secure <= 1'b0;
        end else if (go && !lock_hit) begin
            case (op)
                fcs_pkg::C_LP: fuse[page[5:2]] <= 1'b0;
                fcs_pkg::C_UP: fuse[page[5:2]] <= 1'b1;
                fcs_pkg::C_WGPB: fuse[page_number_field[4:0]] <= 1'b0;
                fcs_pkg::C_EGPB: fuse[page_number_field[4:0]] <= 1'b1;
                fcs_pkg::C_SSB: secure <= 1'b1;
                default: begin
                end
            endcase
        end else if (state == fcs_pkg::ST_RUN && last_step && op == fcs_pkg::C_EA) begin
            fuse   <= fcs_pkg::FUSE_RESET;
            secure <= 1'b0;
        end
    end

    // ****************************************
    // Flash array and quick page read
    // ****************************************
    always_ff @(posedge aclk) begin
        if (state == fcs_pkg::ST_RUN && op != fcs_pkg::C_QPR) begin
            mem[run_addr] <= (op == fcs_pkg::C_WP) ? pbuf[widx[2:0]] : 32'hffffffff;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            qacc <= 1'b1;
            quick_read_result_bit <= 1'b0;
        end else if (state == fcs_pkg::ST_PEND) begin
            qacc <= 1'b1;
        end else if (state == fcs_pkg::ST_RUN && op == fcs_pkg::C_QPR) begin
            qacc <= qacc & (&run_word);
            if (last_step) begin
                quick_read_result_bit <= qacc & (&run_word);
            end
        end
    end

    // ****************************************
    // Page buffer
    // ****************************************
    always_ff @(posedge aclk) begin
        if (go && op == fcs_pkg::C_CPB) begin
            for (int i = 0; i < fcs_pkg::WORDS; i++) begin
                pbuf[i] <= 32'hffffffff;
            end
        end else if (hs_req && hs_write && !hs_ack && state == fcs_pkg::ST_IDLE && !wr_cmd) begin
            pbuf[hs_addr[2:0]] <= pbuf[hs_addr[2:0]] & hs_wdata;
        end
    end

    // ****************************************
    // Read bus and outputs
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hs_ack   <= 1'b0;
            hs_rdata <= 32'h00000000;
        end else begin
            hs_ack <= hs_req && !hs_ack && state == fcs_pkg::ST_IDLE && !wr_cmd;
            if (hs_req && !hs_write) begin
                hs_rdata <= mem[hs_addr];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            volatile_wipe <= 1'b0;
            irq           <= 1'b0;
        end else begin
            volatile_wipe <= go && !lock_hit && op == fcs_pkg::C_EA;
            irq <= (rdy_ie && ready && op != fcs_pkg::C_QPR) ||
                   (lock_error_flag_ie && (lock_error_flag || lock_error_flag_set));
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    a_ready_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_cmd && state == fcs_pkg::ST_IDLE |=> !ready)
        else $error("ready not cleared by command");
    a_ready_returns: assert property (@(posedge aclk) disable iff (!aresetn)
        state == fcs_pkg::ST_DONE |=> ready && state == fcs_pkg::ST_IDLE)
        else $error("ready not set on completion");
    a_start_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        state == fcs_pkg::ST_PEND && hs_req |=> state == fcs_pkg::ST_PEND)
        else $error("command started on busy read bus");
    a_start_first: assert property (@(posedge aclk) disable iff (!aresetn)
        state == fcs_pkg::ST_PEND && !hs_req |=> state != fcs_pkg::ST_PEND)
        else $error("command missed idle cycle");
    a_programming_error_flag_busy: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_cmd && state != fcs_pkg::ST_IDLE |=> programming_error_flag && $stable(op))
        else $error("busy command not rejected");
    a_programming_error_flag_key: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_cmd && state == fcs_pkg::ST_IDLE && w_data[31:24] != fcs_pkg::CMD_KEY
        |=> programming_error_flag ##1 state == fcs_pkg::ST_IDLE)
        else $error("bad key not flagged");
    a_status_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_stat && !programming_error_flag_set && !lock_error_flag_set |=> !programming_error_flag && !lock_error_flag)
        else $error("status read did not clear errors");
    a_lock_refuse: assert property (@(posedge aclk) disable iff (!aresetn)
        go && lock_hit |=> lock_error_flag && state == fcs_pkg::ST_DONE)
        else $error("locked page not refused");
    a_bus_stall: assert property (@(posedge aclk) disable iff (!aresetn)
        state != fcs_pkg::ST_IDLE && $past(state) != fcs_pkg::ST_IDLE |-> !hs_ack)
        else $error("read bus served while busy");
    a_irq_ready: assert property (@(posedge aclk) disable iff (!aresetn)
        rdy_ie && ready && op != fcs_pkg::C_QPR |=> irq)
        else $error("ready interrupt missing");

endmodule : fcs_sequencer
`default_nettype wire

// *** verif/fcs_hs_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcs_hs_master (
    input  wire logic                         aclk,
    output var  logic                         hs_req,
    output var  logic                         hs_write,
    output var  logic [fcs_pkg::MEM_BITS-1:0] hs_addr,
    output var  logic [31:0]                  hs_wdata,
    input  wire logic                         hs_ack,
    input  wire logic [31:0]                  hs_rdata
);
    // ****
    // Word access, released after ack, then one idle cycle
    // ****
    initial begin
        hs_req   = 1'b0;
        hs_write = 1'b0;
        hs_addr  = '0;
        hs_wdata = '0;
    end
    task automatic xfer(input logic wr, input logic [8:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic ok);
        hs_req   <= 1'b1;
        hs_write <= wr;
        hs_addr  <= a;
        hs_wdata <= d;
        for (int i = 0; i < 50 && hs_ack !== 1'b1; i++) @(posedge aclk);
        q  = hs_rdata;
        ok = (hs_ack === 1'b1);
        hs_req   <= 1'b0;
        hs_addr  <= ~a;
        hs_wdata <= ~d;
        @(posedge aclk);
    endtask : xfer
endmodule : fcs_hs_master
`default_nettype wire

// *** verif/flash_command_sequencer_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module flash_command_sequencer_tb_top;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, hs_req, hs_write, hs_ack;
    logic        volatile_wipe, irq;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, hs_wdata, hs_rdata, s, acc, first, d1, d2, hd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rr, br;
    logic [8:0]  hs_addr;
    logic [5:0]  p, q;
    logic [2:0]  w;
    int          failures = 0, samples_checked = 0, wipes = 0;
    logic [31:0] bad [2] = '{32'h5a000003, 32'ha500003f};

    fcs_sequencer dut_u (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
        .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
        .araddr, .rvalid, .rready, .rdata, .rresp, .hs_req, .hs_write, .hs_addr,
        .hs_wdata, .hs_ack, .hs_rdata, .volatile_wipe, .irq);
    fcs_hs_master hs_u (.aclk, .hs_req, .hs_write, .hs_addr, .hs_wdata, .hs_ack,
        .hs_rdata);

    // ****
    // Clock, monitor and bus tasks
    // ****
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) if (volatile_wipe === 1'b1) wipes <= wipes + 1;

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim
    task automatic tmo();
        failures++;
        $display("mismatch at %0t: wait ran out", $time);
        end_sim();
    endtask : tmo
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        br = bresp;
        if (bvalid !== 1'b1) tmo();
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        d = rdata;
        rr = rresp;
        if (rvalid !== 1'b1) tmo();
    endtask : rd
    task automatic hs(input logic w_en, input logic [8:0] a, input logic [31:0] d);
        logic ok;
        hs_u.xfer(w_en, a, d, hd, ok);
        if (!ok) tmo();
    endtask : hs
    task automatic wait_rdy();
        acc = '0;
        for (int i = 0; i < 300; i++) begin
            rd(fcs_pkg::OFS_STATUS, s);
            if (i == 0) first = s;
            acc = acc | s;
            if (s[0] === 1'b1) return;
        end
        tmo();
    endtask : wait_rdy
    task automatic cmd(input logic [5:0] c, input logic [5:0] pg);
        wr(fcs_pkg::OFS_CMD, {fcs_pkg::CMD_KEY, 10'h0, pg, 2'h0, c});
    endtask : cmd
    task automatic op(input logic [5:0] c, input logic [5:0] pg);
        cmd(c, pg);
        wait_rdy();
    endtask : op

    // ****
    // Scenarios
    // ****
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        void'($urandom(32'hd8f92cbc));
        p = 6'($urandom_range(63, 4));
        q = p ^ 6'h20;
        w = 3'($urandom);
        d1 = $urandom;
        d2 = $urandom;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(fcs_pkg::OFS_STATUS, s);
        chk(s & 32'h1d, 32'h1);
        rd(fcs_pkg::OFS_FUSE, s);
        chk(s, fcs_pkg::FUSE_RESET);
        rd(8'h40, s);
        chk(rr, fcs_pkg::RESP_SLV);
        wr(8'h40, 32'h0);
        chk(br, fcs_pkg::RESP_SLV);
        wstrb <= 4'h3;
        wr(fcs_pkg::OFS_CMD, {fcs_pkg::CMD_KEY, 18'h0, fcs_pkg::C_EA});
        wstrb <= 4'hf;
        rd(fcs_pkg::OFS_CMD, s);
        chk(s, 32'h0);
        wr(fcs_pkg::OFS_CTRL, 32'h1);
        foreach (bad[i]) begin
            wr(fcs_pkg::OFS_CMD, bad[i]);
            wait_rdy();
            chk(acc[fcs_pkg::BIT_PROGRAMMING_ERROR_FLAG], 1'b1);
            rd(fcs_pkg::OFS_STATUS, s);
            chk(s[fcs_pkg::BIT_PROGRAMMING_ERROR_FLAG], 1'b0);
        end
        $display("test reset and bad commands done");
        op(fcs_pkg::C_EA, 6'h0);
        chk(acc[fcs_pkg::BIT_LOCK_ERROR_FLAG], 1'b0);
        chk(wipes, 32'h1);
        chk(irq, 1'b1);
        op(fcs_pkg::C_QPR, p);
        chk(s[fcs_pkg::BIT_QUICK_READ_RESULT_BIT], 1'b1);
        chk(irq, 1'b0);
        op(fcs_pkg::C_CPB, 6'h0);
        hs(1'b1, {q, w}, d1);
        hs(1'b1, {p, w}, d2);
        rd(fcs_pkg::OFS_CMD, s);
        chk(s[13:8], p);
        cmd(fcs_pkg::C_WP, p);
        cmd(fcs_pkg::C_CPB, 6'h0);
        wait_rdy();
        chk(first[0], 1'b0);
        chk(acc[fcs_pkg::BIT_PROGRAMMING_ERROR_FLAG], 1'b1);
        hs(1'b0, {p, w}, 32'h0);
        chk(hd, d1 & d2);
        hs(1'b0, {p, w + 3'h1}, 32'h0);
        chk(hd, 32'hffffffff);
        op(fcs_pkg::C_QPR, p);
        chk(s[fcs_pkg::BIT_QUICK_READ_RESULT_BIT], &(d1 & d2));
        $display("test erase and page write done");
        op(fcs_pkg::C_LP, p);
        rd(fcs_pkg::OFS_FUSE, s);
        chk(s, ~(32'h1 << p[5:2]));
        wr(fcs_pkg::OFS_CTRL, 32'h4);
        cmd(fcs_pkg::C_WP, p);
        for (int i = 0; i < 100 && irq !== 1'b1; i++) @(posedge aclk);
        chk(irq, 1'b1);
        wait_rdy();
        chk(acc[fcs_pkg::BIT_LOCK_ERROR_FLAG], 1'b1);
        op(fcs_pkg::C_EA, 6'h0);
        chk(acc[fcs_pkg::BIT_LOCK_ERROR_FLAG], 1'b1);
        chk(wipes, 32'h1);
        op(fcs_pkg::C_UP, p);
        rd(fcs_pkg::OFS_FUSE, s);
        chk(s, fcs_pkg::FUSE_RESET);
        op(fcs_pkg::C_WGPB, 6'd17);
        op(fcs_pkg::C_EP, 6'h1);
        chk(acc[fcs_pkg::BIT_LOCK_ERROR_FLAG], 1'b1);
        op(fcs_pkg::C_EP, 6'h2);
        chk(acc[fcs_pkg::BIT_LOCK_ERROR_FLAG], 1'b0);
        op(fcs_pkg::C_EGPB, 6'd17);
        $display("test locks done");
        end_sim();
    end
endmodule : flash_command_sequencer_tb_top
`default_nettype wire
